// ===== ssm_defines.svh
`ifndef SSM_DEFINES_SVH
`define SSM_DEFINES_SVH
`define SSM_VEC_W      128
`define SSM_HALF_W     64
`define SSM_IMM_W      8
`define SSM_SEL_W      2
`define SSM_RC_NEAR    2'h0
`define SSM_RC_DOWN    2'h1
`define SSM_RC_UP      2'h2
`define SSM_RC_ZERO    2'h3
`define SSM_SP_BIAS    127
`define SSM_DP_BIAS    1023
`define SSM_SP_FRAC    23
`define SSM_DP_FRAC    52
`define SSM_INT_INDEF  32'h80000000
`endif

// ===== ssm_pkg.sv
`include "ssm_defines.svh"
package ssm_pkg;
  typedef enum logic [5:0] {
    op_word_shuf_narrow, op_low_half_shuf, op_high_half_shuf, op_dword_shuf,
    op_byte_shuf, op_blend_byte, op_blend_word, op_low_quad_ilv, op_high_quad_ilv,
    op_narrow_to_wide, op_wide_to_narrow,
    op_cvt_i2s, op_cvt_s2i, op_cvt_i2d, op_cvt_d2i,
    op_round_ps, op_round_pd, op_round_ss, op_round_sd,
    op_widen_bw, op_widen_bd, op_widen_bq, op_widen_wd, op_widen_wq, op_widen_dq,
    op_subus_b, op_subus_w, op_abs_b, op_abs_w, op_abs_d,
    op_shl_w, op_shl_d, op_shr_w, op_shr_d,
    op_cmpeq_b, op_cmpeq_w, op_cmpeq_d
  } ssm_op_type;

  typedef struct packed {
    logic                   valid;
    ssm_op_type             op;
    logic [`SSM_IMM_W-1:0]  imm;
    logic                   sign_ext;
    logic [`SSM_VEC_W-1:0]  dst;
    logic [`SSM_VEC_W-1:0]  src;
    logic [`SSM_VEC_W-1:0]  mask;
    logic [`SSM_HALF_W-1:0] narrow;
  } ssm_req_type;

  typedef struct packed {
    logic                   valid;
    logic [`SSM_VEC_W-1:0]  wide;
    logic [`SSM_HALF_W-1:0] narrow;
  } ssm_rsp_type;
endpackage

// ===== ssm_shuffle4.sv
`timescale 1ns/1ps
`include "ssm_defines.svh"
module ssm_shuffle4
  import ssm_pkg::*;
#(
  parameter int ELEM_W = 16
)
(
  input  wire logic [4*ELEM_W-1:0]   src_in,
  input  wire logic [`SSM_IMM_W-1:0] sel_in,
  output logic      [4*ELEM_W-1:0]   shuf_out
);
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_elem
      wire [`SSM_SEL_W-1:0] pick = sel_in[2*i +: 2];
      assign shuf_out[i*ELEM_W +: ELEM_W] = src_in[pick*ELEM_W +: ELEM_W];
    end
  endgenerate
endmodule

// ===== ssm_lane_alu.sv
`timescale 1ns/1ps
`include "ssm_defines.svh"
module ssm_lane_alu
  import ssm_pkg::*;
#(
  parameter int ELEM_W = 8
)
(
  input  wire logic [`SSM_VEC_W-1:0] a_in,
  input  wire logic [`SSM_VEC_W-1:0] b_in,
  input  wire logic [`SSM_IMM_W-1:0] shamt_in,
  output logic      [`SSM_VEC_W-1:0] subus_out,
  output logic      [`SSM_VEC_W-1:0] abs_out,
  output logic      [`SSM_VEC_W-1:0] eq_out,
  output logic      [`SSM_VEC_W-1:0] shl_out,
  output logic      [`SSM_VEC_W-1:0] shr_out
);
  localparam int LANES = `SSM_VEC_W / ELEM_W;
  genvar i;
  generate
    for (i = 0; i < LANES; i++)
    begin : g_lane
      wire [ELEM_W-1:0] a    = a_in[i*ELEM_W +: ELEM_W];
      wire [ELEM_W-1:0] b    = b_in[i*ELEM_W +: ELEM_W];
      wire [ELEM_W:0]   diff = {1'b0, a} - {1'b0, b};
      wire              over = shamt_in >= ELEM_W;
      assign subus_out[i*ELEM_W +: ELEM_W] = diff[ELEM_W] ? '0 : diff[ELEM_W-1:0];
      // most negative value maps to itself
      assign abs_out[i*ELEM_W +: ELEM_W] = b[ELEM_W-1] ? (~b + 1'b1) : b;
      assign eq_out[i*ELEM_W +: ELEM_W] = (a == b) ? '1 : '0;
      assign shl_out[i*ELEM_W +: ELEM_W] = over ? '0 : (a << shamt_in);
      assign shr_out[i*ELEM_W +: ELEM_W] = over ? '0 : (a >> shamt_in);
    end
  endgenerate
endmodule

// ===== ssm_datapath.sv
`timescale 1ns/1ps
`include "ssm_defines.svh"
// Functional notes
// - narrow word shuffle picks each of four words from 64-bit source
// - half word shuffles permute one 64-bit half, pass other half
// - doubleword shuffle places any source dword in any result dword
// - byte shuffle draws each result byte from the 16-byte operand
// - blends take source element where mask bit set, else destination
// - quad interleaves join destination and source low or high halves
// - narrow to wide move copies 64 bits, zeroes upper half
// - wide to narrow move copies only the low 64 bits
// - four-lane single and two-lane double conversions with int32
// - four rounding ops use instruction rounding, keep float format
// - widening of bytes, words, dwords with sign or zero extension
// - unsigned saturating subtract for bytes and words only
// - absolute value on 128 bits at byte, word, dword size
// - shifts only for word and dword elements
// - no operation loads an immediate constant into a vector
// - compare equal of a register with itself gives all ones
module ssm_datapath
  import ssm_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire ssm_req_type req_in,
  output ssm_rsp_type      rsp_out
);
  wire [`SSM_VEC_W-1:0] dst = req_in.dst;
  wire [`SSM_VEC_W-1:0] src = req_in.src;
  wire [1:0]            rc  = req_in.imm[1:0];

  function automatic int msb_pos(input logic [63:0] v);
    int p;
    p = 0;
    for (int k = 0; k < 64; k++)
    begin
      if (v[k])
        p = k;
    end
    return p;
  endfunction

  // m holds the hidden bit at position 52
  function automatic logic [63:0] fp_to_int(input logic s, input int e,
                                            input logic [52:0] m, input logic [1:0] rm);
    int         sh;
    logic [63:0] q;
    logic [63:0] r;
    logic [63:0] half;
    logic [63:0] mag;
    logic        inc;
    sh   = (e > 52) ? 0 : ((e < -2) ? 54 : 52 - e);
    q    = {11'h0, m} >> sh;
    r    = {11'h0, m} - (q << sh);
    half = (64'h1 << sh) >> 1;
    inc  = (rm == `SSM_RC_NEAR) ? ((r > half) || (r == half && r != 64'h0 && q[0])) :
           (rm == `SSM_RC_DOWN) ? (s && r != 64'h0) :
           (rm == `SSM_RC_UP)   ? (!s && r != 64'h0) : 1'b0;
    mag  = q + {63'h0, inc};
    return s ? (~mag + 64'h1) : mag;
  endfunction

  // large integers are truncated toward zero when they lose precision
  function automatic logic [31:0] i2f32(input logic [63:0] v);
    logic        s;
    logic [63:0] mag;
    logic [63:0] nrm;
    int          p;
    s   = v[63];
    mag = s ? (~v + 64'h1) : v;
    p   = msb_pos(mag);
    nrm = mag << (63 - p);
    return (mag == 64'h0) ? 32'h0 : {s, 8'(`SSM_SP_BIAS + p), nrm[62:40]};
  endfunction

  function automatic logic [63:0] i2f64(input logic [63:0] v);
    logic        s;
    logic [63:0] mag;
    logic [63:0] nrm;
    int          p;
    s   = v[63];
    mag = s ? (~v + 64'h1) : v;
    p   = msb_pos(mag);
    nrm = mag << (63 - p);
    return (mag == 64'h0) ? 64'h0 : {s, 11'(`SSM_DP_BIAS + p), nrm[62:11]};
  endfunction

  function automatic logic [52:0] sp_mant(input logic [31:0] f);
    return {|f[30:23], f[22:0], 29'h0};
  endfunction

  function automatic logic [52:0] dp_mant(input logic [63:0] f);
    return {|f[62:52], f[51:0]};
  endfunction

  function automatic logic [31:0] s2i(input logic [31:0] f, input logic [1:0] rm);
    int e;
    e = int'(f[30:23]) - `SSM_SP_BIAS;
    if (e > 30)
      return `SSM_INT_INDEF;
    return 32'(fp_to_int(f[31], e, sp_mant(f), rm));
  endfunction

  function automatic logic [31:0] d2i(input logic [63:0] f, input logic [1:0] rm);
    int e;
    e = int'(f[62:52]) - `SSM_DP_BIAS;
    if (e > 30)
      return `SSM_INT_INDEF;
    return 32'(fp_to_int(f[63], e, dp_mant(f), rm));
  endfunction

  // already integral or not a number: pass through; a zero keeps its sign
  function automatic logic [31:0] round32(input logic [31:0] f, input logic [1:0] rm);
    int          e;
    logic [63:0] v;
    e = int'(f[30:23]) - `SSM_SP_BIAS;
    if (e >= `SSM_SP_FRAC)
      return f;
    v = fp_to_int(f[31], e, sp_mant(f), rm);
    return (v == 64'h0) ? {f[31], 31'h0} : i2f32(v);
  endfunction

  function automatic logic [63:0] round64(input logic [63:0] f, input logic [1:0] rm);
    int          e;
    logic [63:0] v;
    e = int'(f[62:52]) - `SSM_DP_BIAS;
    if (e >= `SSM_DP_FRAC)
      return f;
    v = fp_to_int(f[63], e, dp_mant(f), rm);
    return (v == 64'h0) ? {f[63], 63'h0} : i2f64(v);
  endfunction

  function automatic logic [`SSM_VEC_W-1:0] widen(input logic [`SSM_VEC_W-1:0] a,
                                                  input int sw, input int dw, input logic sgn);
    logic [`SSM_VEC_W-1:0] w;
    int                    lane;
    int                    b;
    w = '0;
    for (int k = 0; k < `SSM_VEC_W; k++)
    begin
      lane = k / dw;
      b    = k % dw;
      w[k] = (b < sw) ? a[lane*sw + b] : (sgn & a[lane*sw + sw - 1]);
    end
    return w;
  endfunction

  logic [`SSM_HALF_W-1:0] shuf_nar;
  logic [`SSM_HALF_W-1:0] shuf_lo;
  logic [`SSM_HALF_W-1:0] shuf_hi;
  logic [`SSM_VEC_W-1:0]  shuf_dw;
  logic [`SSM_VEC_W-1:0]  byte_shuf;
  logic [`SSM_VEC_W-1:0]  blend_b;
  logic [`SSM_VEC_W-1:0]  blend_w;
  logic [`SSM_VEC_W-1:0]  cvt_i2s;
  logic [`SSM_VEC_W-1:0]  cvt_s2i;
  logic [`SSM_VEC_W-1:0]  rnd_ps;
  logic [`SSM_VEC_W-1:0]  cvt_i2d;
  logic [`SSM_HALF_W-1:0] cvt_d2i;
  logic [`SSM_VEC_W-1:0]  rnd_pd;
  logic [`SSM_VEC_W-1:0]  subus_v [4];
  logic [`SSM_VEC_W-1:0]  abs_v   [4];
  logic [`SSM_VEC_W-1:0]  eq_v    [4];
  logic [`SSM_VEC_W-1:0]  shl_v   [4];
  logic [`SSM_VEC_W-1:0]  shr_v   [4];
  logic [`SSM_VEC_W-1:0]  next_wide;
  logic [`SSM_HALF_W-1:0] next_narrow;
  ssm_rsp_type            rsp;
  ssm_req_type            prev;

  // word shuffle of the narrow operand
  ssm_shuffle4 #(.ELEM_W(16)) u_shuf_nar (
    .src_in   (req_in.narrow),
    .sel_in   (req_in.imm),
    .shuf_out (shuf_nar)
  );
  ssm_shuffle4 #(.ELEM_W(16)) u_shuf_lo (
    .src_in   (src[63:0]),
    .sel_in   (req_in.imm),
    .shuf_out (shuf_lo)
  );
  ssm_shuffle4 #(.ELEM_W(16)) u_shuf_hi (
    .src_in   (src[127:64]),
    .sel_in   (req_in.imm),
    .shuf_out (shuf_hi)
  );
  ssm_shuffle4 #(.ELEM_W(32)) u_shuf_dw (
    .src_in   (src),
    .sel_in   (req_in.imm),
    .shuf_out (shuf_dw)
  );

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_alu
      ssm_lane_alu #(.ELEM_W(8 << i)) u_alu (
        .a_in      (dst),
        .b_in      (src),
        .shamt_in  (req_in.imm),
        .subus_out (subus_v[i]),
        .abs_out   (abs_v[i]),
        .eq_out    (eq_v[i]),
        .shl_out   (shl_v[i]),
        .shr_out   (shr_v[i])
      );
    end
    for (i = 0; i < 16; i++)
    begin : g_byte
      // low nibble indexes within the 16 bytes
      assign byte_shuf[i*8 +: 8] = dst[src[i*8 +: 4]*8 +: 8];
      // byte mask from top bit of implicit mask vector
      assign blend_b[i*8 +: 8] = req_in.mask[i*8+7] ? src[i*8 +: 8] : dst[i*8 +: 8];
    end
    for (i = 0; i < 8; i++)
    begin : g_word
      // word mask from the immediate byte
      assign blend_w[i*16 +: 16] = req_in.imm[i] ? src[i*16 +: 16] : dst[i*16 +: 16];
    end
    for (i = 0; i < 4; i++)
    begin : g_sp
      assign cvt_i2s[i*32 +: 32] = i2f32({{32{src[i*32+31]}}, src[i*32 +: 32]});
      assign cvt_s2i[i*32 +: 32] = s2i(src[i*32 +: 32], rc);
      // rounding mode from the instruction only
      assign rnd_ps[i*32 +: 32] = round32(src[i*32 +: 32], rc);
    end
    for (i = 0; i < 2; i++)
    begin : g_dp
      // double lanes against the low two integers
      assign cvt_i2d[i*64 +: 64] = i2f64({{32{src[i*32+31]}}, src[i*32 +: 32]});
      assign cvt_d2i[i*32 +: 32] = d2i(src[i*64 +: 64], rc);
      assign rnd_pd[i*64 +: 64] = round64(src[i*64 +: 64], rc);
    end
  endgenerate

  // the operation set has no immediate load into a vector
  always_comb
  begin
    next_wide   = '0;
    next_narrow = '0;
    unique case (req_in.op)
      op_word_shuf_narrow: next_narrow = shuf_nar;
      op_low_half_shuf:    next_wide = {src[127:64], shuf_lo};
      op_high_half_shuf:   next_wide = {shuf_hi, src[63:0]};
      op_dword_shuf:       next_wide = shuf_dw;
      op_byte_shuf:        next_wide = byte_shuf;
      op_blend_byte:       next_wide = blend_b;
      op_blend_word:       next_wide = blend_w;
      // interleave ignores the unused source half
      op_low_quad_ilv:     next_wide = {src[63:0], dst[63:0]};
      op_high_quad_ilv:    next_wide = {src[127:64], dst[127:64]};
      op_narrow_to_wide:   next_wide = {64'h0, req_in.narrow};
      op_wide_to_narrow:   next_narrow = src[63:0];
      op_cvt_i2s:          next_wide = cvt_i2s;
      op_cvt_s2i:          next_wide = cvt_s2i;
      op_cvt_i2d:          next_wide = cvt_i2d;
      op_cvt_d2i:          next_wide = {64'h0, cvt_d2i};
      op_round_ps:         next_wide = rnd_ps;
      op_round_pd:         next_wide = rnd_pd;
      op_round_ss:         next_wide = {dst[127:32], rnd_ps[31:0]};
      op_round_sd:         next_wide = {dst[127:64], rnd_pd[63:0]};
      op_widen_bw:         next_wide = widen(src, 8, 16, req_in.sign_ext);
      op_widen_bd:         next_wide = widen(src, 8, 32, req_in.sign_ext);
      op_widen_bq:         next_wide = widen(src, 8, 64, req_in.sign_ext);
      op_widen_wd:         next_wide = widen(src, 16, 32, req_in.sign_ext);
      op_widen_wq:         next_wide = widen(src, 16, 64, req_in.sign_ext);
      op_widen_dq:         next_wide = widen(src, 32, 64, req_in.sign_ext);
      op_subus_b:          next_wide = subus_v[0];
      op_subus_w:          next_wide = subus_v[1];
      op_abs_b:            next_wide = abs_v[0];
      op_abs_w:            next_wide = abs_v[1];
      op_abs_d:            next_wide = abs_v[2];
      op_shl_w:            next_wide = shl_v[1];
      op_shl_d:            next_wide = shl_v[2];
      op_shr_w:            next_wide = shr_v[1];
      op_shr_d:            next_wide = shr_v[2];
      op_cmpeq_b:          next_wide = eq_v[0];
      op_cmpeq_w:          next_wide = eq_v[1];
      op_cmpeq_d:          next_wide = eq_v[2];
      default:             next_wide = '0;
    endcase
  end

  // one register stage; data follows the request even when not valid
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      rsp <= '0;
    else
      rsp <= '{valid: req_in.valid, wide: next_wide, narrow: next_narrow};
  end

  // request copy read only by the checks below
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      prev <= '0;
    else
      prev <= req_in;
  end

  assign rsp_out = rsp;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  wire done = rsp.valid;

  pipe_timing_a: assert property (req_in.valid |=> done ##1 (done == $past(req_in.valid)))
    else $error("response valid does not follow request by one cycle");
  shuf_narrow_a: assert property (done && prev.op == op_word_shuf_narrow |->
    rsp.narrow[63:48] == prev.narrow[prev.imm[7:6]*16 +: 16] && rsp.wide == '0)
    else $error("narrow word shuffle picked wrong word");
  low_half_a: assert property (done && prev.op == op_low_half_shuf |->
    rsp.wide[127:64] == prev.src[127:64] && rsp.wide[15:0] == prev.src[prev.imm[1:0]*16 +: 16])
    else $error("low half shuffle wrong");
  dword_shuf_a: assert property (done && prev.op == op_dword_shuf |->
    rsp.wide[127:96] == prev.src[prev.imm[7:6]*32 +: 32])
    else $error("doubleword shuffle wrong");
  byte_range_a: assert property (done && prev.op == op_byte_shuf |->
    rsp.wide[127:120] == prev.dst[prev.src[123:120]*8 +: 8])
    else $error("byte shuffle wrong");
  blend_word_a: assert property (done && prev.op == op_blend_word |->
    rsp.wide[31:16] == (prev.imm[1] ? prev.src[31:16] : prev.dst[31:16]))
    else $error("word blend wrong");
  quad_ilv_a: assert property (done && prev.op == op_high_quad_ilv |->
    rsp.wide == {prev.src[127:64], prev.dst[127:64]})
    else $error("high interleave wrong");
  wide_zero_a: assert property (done && prev.op == op_narrow_to_wide |->
    rsp.wide[127:64] == '0 && rsp.wide[63:0] == prev.narrow)
    else $error("narrow to wide move wrong");
  narrow_copy_a: assert property (done && prev.op == op_wide_to_narrow |->
    rsp.narrow == prev.src[63:0])
    else $error("wide to narrow move wrong");
  d2i_upper_a: assert property (done && prev.op == op_cvt_d2i |->
    rsp.wide[127:64] == '0)
    else $error("double to int upper half not zero");
  scalar_round_a: assert property (done && prev.op == op_round_ss |->
    rsp.wide[127:32] == prev.dst[127:32])
    else $error("scalar round disturbed upper lanes");
  widen_sign_a: assert property (done && prev.op == op_widen_bq |->
    rsp.wide[63:0] == {{56{prev.sign_ext & prev.src[7]}}, prev.src[7:0]})
    else $error("byte to quad widening wrong");
  subus_clamp_a: assert property (done && prev.op == op_subus_w && prev.dst[15:0] < prev.src[15:0] |->
    rsp.wide[15:0] == 16'h0)
    else $error("unsigned saturation failed");
  abs_byte_a: assert property (done && prev.op == op_abs_b && prev.src[7:0] != 8'h80 |->
    !rsp.wide[7])
    else $error("byte magnitude negative");
  shift_clear_a: assert property (done && prev.op == op_shl_w && prev.imm > 8'h0f |->
    rsp.wide == '0)
    else $error("oversized word shift not cleared");
  self_eq_a: assert property (done && prev.op == op_cmpeq_d && prev.dst == prev.src |->
    &rsp.wide)
    else $error("self compare not all ones");

  cov_shuffle: cover property (req_in.valid && req_in.op == op_dword_shuf ##1 done);
  cov_blend: cover property (req_in.valid && req_in.op == op_blend_byte ##1 done);
  cov_round: cover property (req_in.valid && req_in.op == op_round_ps ##1 req_in.valid);
  cov_selfeq: cover property (done && prev.op == op_cmpeq_b && &rsp.wide);
endmodule

// ===== ssm_issue_model.sv
`timescale 1ns/1ps
module ssm_issue_model
  import ssm_pkg::*;
(
  output ssm_req_type req_out
);
  initial req_out = '0;

  // called just after a falling edge, so the request is steady well before the taking edge
  task automatic put(input ssm_req_type r);
    req_out <= r;
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ssm_pkg::*;

  typedef struct {
    ssm_req_type  r;
    logic [127:0] ew;
    logic [63:0]  en;
  } ssm_row_type;

  localparam logic [127:0] sw = 128'h0007_0006_0005_0004_0003_0002_0001_0000;
  localparam logic [127:0] dw = 128'h0017_0016_0015_0014_0013_0012_0011_0010;
  localparam logic [127:0] aa = {8{16'h1020}};
  localparam logic [127:0] bb = {8{16'h2010}};
  localparam logic [127:0] ab = {4{32'hff808001}};
  localparam logic [127:0] wv = {64'hffff_ffff_ffff_ffff, 64'h8000_0000_0000_8081};
  localparam logic [127:0] iv = {32'h0, 32'h2, 32'hffffffff, 32'h1};
  localparam logic [127:0] fl = {32'h4f000000, 32'hbfc00000, 32'h40200000, 32'h3fc00000};
  localparam logic [127:0] dl = {64'hc004000000000000, 64'h3ff8000000000000};
  localparam logic [63:0]  nv = 64'h4444_3333_2222_1111;

  logic        ref_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        sx         = 1'b0;
  ssm_req_type req;
  ssm_rsp_type rsp;
  ssm_row_type rows[$];
  int          error_cnt  = 0;
  int          num_checks = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  ssm_issue_model issue (.req_out(req));
  ssm_datapath dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req), .rsp_out(rsp));

  task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic chkr(input string nm, input logic v, input logic [127:0] w, input logic [63:0] n);
    chk({nm, " valid"}, 256'(rsp.valid), 256'(v));
    chk({nm, " wide"}, 256'(rsp.wide), 256'(w));
    chk({nm, " narrow"}, 256'(rsp.narrow), 256'(n));
  endtask

  task automatic add(input ssm_op_type op, input logic [7:0] imm, input logic [127:0] d,
                     input logic [127:0] s, input logic [127:0] ew, input logic [63:0] en);
    ssm_row_type w;
    w.r = '{valid: 1'b1, op: op, imm: imm, sign_ext: sx, dst: d, src: s, mask: {8{16'h7f80}}, narrow: nv};
    w.ew = ew;
    w.en = en;
    rows.push_back(w);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk_in);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    ssm_req_type q;
    int          i;
    add(op_word_shuf_narrow, 8'h4e, dw, sw, 0, 64'h2222_1111_4444_3333);
    add(op_low_half_shuf, 8'h1b, dw, sw, 128'h0007_0006_0005_0004_0000_0001_0002_0003, 0);
    add(op_high_half_shuf, 8'h00, dw, sw, 128'h0004_0004_0004_0004_0003_0002_0001_0000, 0);
    add(op_dword_shuf, 8'h1b, dw, sw, 128'h0001_0000_0003_0002_0005_0004_0007_0006, 0);
    add(op_dword_shuf, 8'hff, dw, sw, {4{32'h0007_0006}}, 0);
    add(op_byte_shuf, 8'h0, 128'h000102030405060708090a0b0c0d0e0f, 128'hf0f1f2f3f4f5f6f7f8f9fafbfcfdfeff,
        128'h0f0e0d0c0b0a09080706050403020100, 0);
    add(op_blend_word, 8'ha5, dw, sw, 128'h0007_0016_0005_0014_0013_0002_0011_0000, 0);
    add(op_blend_byte, 8'h0, {16{8'haa}}, {16{8'h55}}, {8{16'haa55}}, 0);
    add(op_low_quad_ilv, 8'h0, dw, sw, {sw[63:0], dw[63:0]}, 0);
    add(op_high_quad_ilv, 8'h0, dw, sw, {sw[127:64], dw[127:64]}, 0);
    add(op_narrow_to_wide, 8'h0, dw, sw, {64'h0, nv}, 0);
    add(op_wide_to_narrow, 8'h0, dw, sw, 0, sw[63:0]);
    // conversions and rounding, all four modes
    add(op_cvt_i2s, 8'h0, dw, iv, {32'h0, 32'h40000000, 32'hbf800000, 32'h3f800000}, 0);
    add(op_cvt_s2i, 8'h0, dw, fl, {32'h80000000, 32'hfffffffe, 32'h2, 32'h2}, 0);
    add(op_cvt_s2i, 8'h3, dw, fl, {32'h80000000, 32'hffffffff, 32'h2, 32'h1}, 0);
    add(op_cvt_s2i, 8'h2, dw, fl, {32'h80000000, 32'hffffffff, 32'h3, 32'h2}, 0);
    add(op_cvt_i2d, 8'h0, dw, iv, {64'hbff0000000000000, 64'h3ff0000000000000}, 0);
    add(op_cvt_d2i, 8'h0, dw, dl, {64'h0, 32'hfffffffe, 32'h2}, 0);
    add(op_round_ps, 8'h1, dw, fl, {32'h4f000000, 32'hc0000000, 32'h40000000, 32'h3f800000}, 0);
    add(op_round_pd, 8'h3, dw, dl, {64'hc000000000000000, 64'h3ff0000000000000}, 0);
    add(op_round_ss, 8'h0, dw, fl, {dw[127:32], 32'h40000000}, 0);
    add(op_round_sd, 8'h2, dw, dl, {dw[127:64], 64'h4000000000000000}, 0);
    sx = 1'b1;
    add(op_widen_bw, 8'h0, dw, wv, 128'hff80_0000_0000_0000_0000_0000_ff80_ff81, 0);
    add(op_widen_bd, 8'h0, dw, wv, {64'h0, 32'hffffff80, 32'hffffff81}, 0);
    add(op_widen_bq, 8'h0, dw, wv, {64'hffffffffffffff80, 64'hffffffffffffff81}, 0);
    add(op_widen_wd, 8'h0, dw, wv, {32'hffff8000, 64'h0, 32'hffff8081}, 0);
    add(op_widen_wq, 8'h0, dw, wv, {64'h0, 64'hffffffffffff8081}, 0);
    add(op_widen_dq, 8'h0, dw, wv, {64'hffffffff80000000, 64'h8081}, 0);
    sx = 1'b0;
    add(op_widen_bw, 8'h0, dw, wv, 128'h0080_0000_0000_0000_0000_0000_0080_0081, 0);
    add(op_widen_dq, 8'h0, dw, wv, {64'h80000000, 64'h8081}, 0);
    add(op_subus_b, 8'h0, aa, bb, {8{16'h0010}}, 0);
    add(op_subus_w, 8'h0, aa, bb, 0, 0);
    add(op_subus_w, 8'h0, bb, aa, {8{16'h0ff0}}, 0);
    add(op_abs_b, 8'h0, dw, ab, {4{32'h01808001}}, 0);
    add(op_abs_w, 8'h0, dw, ab, {4{32'h00807fff}}, 0);
    add(op_abs_d, 8'h0, dw, ab, {4{32'h007f7fff}}, 0);
    add(op_shl_w, 8'h4, aa, sw, {8{16'h0200}}, 0);
    add(op_shl_w, 8'hf, ab, sw, {4{32'h00008000}}, 0);
    add(op_shl_w, 8'h10, aa, sw, 0, 0);
    add(op_shr_d, 8'h4, aa, sw, {4{32'h01020102}}, 0);
    add(op_shr_d, 8'h1f, ab, sw, {4{32'h1}}, 0);
    add(op_shr_d, 8'h20, ab, sw, 0, 0);
    add(op_shl_d, 8'h8, aa, sw, {4{32'h20102000}}, 0);
    add(op_shl_d, 8'h20, aa, sw, 0, 0);
    add(op_shr_w, 8'h4, aa, sw, {8{16'h0102}}, 0);
    add(op_shr_w, 8'hf, ab, sw, {4{32'h00010001}}, 0);
    add(op_cmpeq_b, 8'h0, aa, aa, '1, 0);
    add(op_cmpeq_w, 8'h0, aa, aa, '1, 0);
    add(op_cmpeq_d, 8'h0, aa, aa, '1, 0);
    add(op_cmpeq_b, 8'h0, aa, {8{16'h1030}}, {8{16'hff00}}, 0);
    add(op_cmpeq_w, 8'h0, aa, bb, 0, 0);

    // a live request during reset must not reach the output
    @(negedge ref_clk_in);
    issue.put(rows[0].r);
    repeat (19) @(negedge ref_clk_in);
    chk("rsp in reset", 256'(rsp), 256'h0);
    issue.put('0);
    rst_in = 1'b0;
    @(negedge ref_clk_in);
    chk("rsp after release", 256'(rsp), 256'h0);

    // back to back: check row i-1 while issuing row i
    for (i = 0; i <= rows.size(); i++)
    begin
      @(negedge ref_clk_in);
      if (i > 0)
        chkr(rows[i-1].r.op.name(), 1'b1, rows[i-1].ew, rows[i-1].en);
      issue.put(i < rows.size() ? rows[i].r : ssm_req_type'('0));
    end
    @(negedge ref_clk_in);
    chk("idle valid", 256'(rsp.valid), 256'h0);

    q = '1;
    q.op = ssm_op_type'(6'h3f);
    issue.put(q);
    @(negedge ref_clk_in);
    chkr("unused code", 1'b1, 0, 0);
    q.valid = 1'b0;
    q.op = op_cmpeq_d;
    issue.put(q);
    @(negedge ref_clk_in);
    chkr("no valid", 1'b0, '1, 0);
    q.valid = 1'b1;
    issue.put(q);
    @(negedge ref_clk_in);
    rst_in = 1'b1;
    @(negedge ref_clk_in);
    chk("mid reset", 256'(rsp), 256'h0);
    rst_in = 1'b0;
    // first request waits one edge after the release edge
    issue.put('0);
    @(negedge ref_clk_in);
    chk("rsp after mid release", 256'(rsp), 256'h0);
    issue.put(q);
    @(negedge ref_clk_in);
    chkr("after mid reset", 1'b1, '1, 0);
    end_of_test();
  end
endmodule
